// *** rtl/program_sequencer_interrupt_ctrl.sv ***
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "seq_params.svh"
module program_sequencer_interrupt_ctrl #(
  parameter int BTC_N = 128,
  parameter int QWORDS = 20,
  parameter logic [3:0] INT_EDGE = 4'h0
) (
  input wire logic MCLK_I, // core clock
  input wire logic RESET_I, // synchronous reset
  input wire logic [7:0] ADDR_I, // register address
  input wire logic [31:0] WDATA_I, // register write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [31:0] RDATA_O, // read data
  output logic FETCH_REQ_O, // fetch request
  output logic [15:0] FETCH_ADDR_O, // quad aligned word address
  input wire logic FETCH_VALID_I, // fetch block returned
  input wire logic [127:0] FETCH_DATA_I, // fetched block
  input wire logic COND_I, // branch condition at resolve
  input wire logic [3:0] EXT_IRQ_N_I, // external interrupt pins
  input wire logic [3:0] INT_SRC_I, // internal interrupt sources
  output logic [127:0] ISSUE_LINE_O, // line entering execution
  output logic [2:0] ISSUE_CNT_O, // words in that line
  output logic [15:0] ISSUE_PC_O, // address of that line
  output logic [4:0] EXEC_VALID_O, // execution stage valid bits
  output logic RETIRE_O, // line in last stage
  output logic STALL_O, // interlock stall
  output logic ABORT_O, // pipe aborted by exception
  output seq_pkg::seq_state_t STATE_O, // sequencer state
  output logic IRQ_O // block interrupt
);
  import seq_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] latch, mask, insvc;
  logic [7:0] ctrl;
  logic [3:0] stat, smask;
  logic [15:0] stalls, exc_vec;
  logic [15:0] vec [`NSRC];
  logic [3:0] s1, s2, s3, ext_act, ext_prev, int_prev;
  logic [7:0] src_set, clr_take;
  seq_state_t st;
  logic [3:0] ev;
  logic wr_vec;
  logic [2:0] vidx;

  assign wr_vec = WR_I && ADDR_I >= `A_VEC0 && ADDR_I <= `A_VECN;
  assign vidx = ADDR_I[4:2];

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      s1 <= 4'hF;
      s2 <= 4'hF;
      s3 <= 4'hF;
      ext_act <= 4'h0;
      ext_prev <= 4'h0;
      int_prev <= 4'h0;
    end else begin
      s1 <= EXT_IRQ_N_I;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < `NEXT; i++) begin
        if (s2[i] == s3[i]) begin
          ext_act[i] <= ~s3[i];
        end
      end
      ext_prev <= ext_act;
      int_prev <= INT_SRC_I;
    end
  end

  always_comb begin
    for (int i = 0; i < `NEXT; i++) begin
      src_set[i] = ctrl[4+i] ? ext_act[i] & ~ext_prev[i] : ext_act[i];
      src_set[4+i] = INT_EDGE[i] ? INT_SRC_I[i] & ~int_prev[i] : INT_SRC_I[i];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      latch <= 8'h00;
    end else begin
      // A new edge or level wins over a clear in the same cycle.
      latch <= (latch & ~(clr_take | ((WR_I && ADDR_I == `A_LATCH) ? WDATA_I[7:0] : 8'h00)))
        | src_set;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mask <= 8'h00;
      ctrl <= 8'h00;
      smask <= 4'h0;
      exc_vec <= 16'h0000;
      for (int i = 0; i < `NSRC; i++) begin
        vec[i] <= 16'h0000;
      end
    end else if (WR_I) begin
      if (ADDR_I == `A_MASK) mask <= WDATA_I[7:0];
      if (ADDR_I == `A_CTRL) ctrl <= WDATA_I[7:0];
      if (ADDR_I == `A_SMASK) smask <= WDATA_I[3:0];
      if (ADDR_I == `A_EXCVEC) exc_vec <= WDATA_I[15:0];
      if (wr_vec) vec[vidx] <= WDATA_I[15:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      stat <= 4'h0;
    end else begin
      stat <= (stat & ~((WR_I && ADDR_I == `A_STAT) ? WDATA_I[3:0] : 4'h0)) | ev;
    end
  end

  assign IRQ_O = |(stat & smask);

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      RDATA_O <= 32'h0000_0000;
      if (ADDR_I == `A_LATCH) RDATA_O[7:0] <= latch;
      if (ADDR_I == `A_MASK) RDATA_O[7:0] <= mask;
      if (ADDR_I == `A_CTRL) RDATA_O[7:0] <= ctrl;
      if (ADDR_I == `A_INSVC) RDATA_O[7:0] <= insvc;
      if (ADDR_I == `A_STAT) RDATA_O[3:0] <= stat;
      if (ADDR_I == `A_SMASK) RDATA_O[3:0] <= smask;
      if (ADDR_I == `A_STALLS) RDATA_O[15:0] <= stalls;
      if (ADDR_I == `A_EXCVEC) RDATA_O[15:0] <= exc_vec;
      if (ADDR_I >= `A_VEC0 && ADDR_I <= `A_VECN) RDATA_O[15:0] <= vec[vidx];
    end
  end

  // ----------------------------------------
  // Interrupt priority and nesting
  // ----------------------------------------
  logic [7:0] cand;
  logic [2:0] cp, ip;
  logic irq_ok;

  assign cand = latch & mask & {8{ctrl[`C_GIE]}};

  always_comb begin
    cp = 3'd0;
    ip = 3'd0;
    for (int i = `NSRC - 1; i >= 0; i--) begin
      if (cand[i]) cp = 3'(i);
      if (insvc[i]) ip = 3'(i);
    end
  end

  // Lower index is higher priority; nesting admits only a higher one.
  assign irq_ok = cand != 8'h00 && (insvc == 8'h00 || (ctrl[`C_NEST] && cp < ip));

  // ----------------------------------------
  // Line queue
  // ----------------------------------------
  logic [31:0] q [QWORDS];
  logic [5:0] wcnt;
  logic [1:0] skip, out_n, drop;
  logic [15:0] fetch_pc, head_pc;
  logic [2:0] len;
  logic line_ok, dep, fire, rd, push_acc;
  logic [15:0] rd_pc;

  always_comb begin
    len = 3'd0;
    for (int k = `LINE_W - 1; k >= 0; k--) begin
      if (q[k][`F_LAST] && k < int'(wcnt)) len = 3'(k + 1);
    end
  end
  assign line_ok = len != 3'd0;

  // ----------------------------------------
  // Scoreboard
  // ----------------------------------------
  logic [1:0] sb [64];
  always_comb begin
    dep = 1'b0;
    for (int k = 0; k < `LINE_W; k++) begin
      if (k < int'(len) && !q[k][30]) begin
        if (sb[{q[k][`F_SRCF], q[k][`F_SA]}] != 2'd0) dep = 1'b1;
        if (sb[{q[k][`F_SRCF], q[k][`F_SB]}] != 2'd0) dep = 1'b1;
      end
    end
  end

  logic mp, trap;
  assign fire = line_ok && !dep && st == S_RUN && !irq_ok && !mp;
  assign STALL_O = line_ok && dep;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int r = 0; r < 64; r++) begin
        sb[r] <= 2'd0;
      end
    end else begin
      for (int r = 0; r < 64; r++) begin
        if (sb[r] != 2'd0) sb[r] <= sb[r] - 2'd1;
      end
      if (fire) begin
        for (int k = 0; k < `LINE_W; k++) begin
          if (k < int'(len) && q[k][`F_CLS] == CL_CMP)
            sb[{1'b0, q[k][`F_DST]}] <= 2'(`LAT_CMP - 1);
          if (k < int'(len) && q[k][`F_CLS] == CL_INTEGER_ADDRESS_UNIT)
            sb[{1'b1, q[k][`F_DST]}] <= 2'(`LAT_INTEGER_ADDRESS_UNIT - 1);
        end
      end
    end
  end

  // ----------------------------------------
  // Branch decode and target cache
  // ----------------------------------------
  logic [31:0] bw;
  logic has_br;
  always_comb begin
    bw = 32'h0000_0000;
    has_br = 1'b0;
    trap = 1'b0;
    for (int k = `LINE_W - 1; k >= 0; k--) begin
      if (k < int'(len) && q[k][`F_CLS] == CL_BR) begin
        bw = q[k];
        has_br = 1'b1;
      end
      if (k < int'(len) && q[k][`F_CLS] == CL_CTL && q[k][`F_TRAP]) trap = 1'b1;
    end
  end

  logic btc_v [BTC_N];
  logic [8:0] btc_tag [BTC_N];
  logic [15:0] btc_tgt [BTC_N];
  logic pred;
  logic [15:0] next_pc;
  assign pred = btc_v[head_pc[6:0]] && btc_tag[head_pc[6:0]] == head_pc[15:7];
  assign next_pc = head_pc + 16'(len);

  // ----------------------------------------
  // Execution stages
  // ----------------------------------------
  logic [4:0] ex_v, kill;
  logic [127:0] ex_line [`EX_STAGES];
  logic [2:0] ex_cnt [`EX_STAGES];
  logic [15:0] ex_pc [`EX_STAGES], ex_tg [`EX_STAGES], ex_np [`EX_STAGES];
  logic [4:0] ex_br, ex_pt, ex_call;
  logic taken;
  logic [15:0] rs [4];
  logic [1:0] rsp;
  logic push, pop, take, interrupt_return_instr;
  logic [15:0] push_v;

  assign taken = COND_I;
  assign mp = ex_v[`RES_STG] && ex_br[`RES_STG] && taken != ex_pt[`RES_STG];

  always_comb begin
    rd = 1'b0;
    rd_pc = 16'h0000;
    kill = 5'h00;
    push = 1'b0;
    pop = 1'b0;
    push_v = 16'h0000;
    take = 1'b0;
    interrupt_return_instr = 1'b0;
    clr_take = 8'h00;
    ABORT_O = 1'b0;
    if (mp) begin
      rd = 1'b1;
      rd_pc = taken ? ex_tg[`RES_STG] : ex_np[`RES_STG];
      kill = 5'h03;
      push = taken && ex_call[`RES_STG];
      pop = !taken && ex_call[`RES_STG];
      push_v = ex_np[`RES_STG];
    end else if (fire && trap) begin
      rd = 1'b1;
      rd_pc = exc_vec;
      kill = 5'h1F;
      ABORT_O = 1'b1;
      push = 1'b1;
      push_v = next_pc;
    end else if (st == S_DRAIN && ex_v == 5'h00 && irq_ok) begin
      take = 1'b1;
      rd = 1'b1;
      rd_pc = vec[cp];
      clr_take[cp] = 1'b1;
      push = 1'b1;
      push_v = head_pc;
    end else if (fire && has_br) begin
      unique case (brkind_t'(bw[`F_KIND]))
        BR_JUMP, BR_CALL: begin
          if (!bw[`F_COND] || pred) begin
            rd = 1'b1;
            rd_pc = bw[`F_COND] ? btc_tgt[head_pc[6:0]] : bw[`F_TGT];
            push = bw[`F_KIND] == BR_CALL;
            push_v = next_pc;
          end
        end
        BR_RTS, BR_RTI: begin
          rd = 1'b1;
          rd_pc = rs[rsp - 2'd1];
          pop = 1'b1;
          interrupt_return_instr = bw[`F_KIND] == BR_RTI;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rsp <= 2'd0;
      for (int i = 0; i < 4; i++) begin
        rs[i] <= 16'h0000;
      end
    end else if (push) begin
      rs[rsp] <= push_v;
      rsp <= rsp + 2'd1;
    end else if (pop) begin
      rsp <= rsp - 2'd1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      insvc <= 8'h00;
    end else if (take) begin
      insvc <= insvc | clr_take;
    end else if (interrupt_return_instr) begin
      insvc <= insvc & ~(8'h01 << ip);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      st <= S_RUN;
    end else begin
      unique case (st)
        S_RUN: if (irq_ok && !mp) st <= S_DRAIN;
        S_DRAIN: if (take || !irq_ok) st <= S_RUN;
      endcase
    end
  end
  assign STATE_O = st;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < BTC_N; i++) begin
        btc_v[i] <= 1'b0;
        btc_tag[i] <= 9'h000;
        btc_tgt[i] <= 16'h0000;
      end
    end else if (ex_v[`RES_STG] && ex_br[`RES_STG]) begin
      btc_v[ex_pc[`RES_STG][6:0]] <= taken;
      btc_tag[ex_pc[`RES_STG][6:0]] <= ex_pc[`RES_STG][15:7];
      btc_tgt[ex_pc[`RES_STG][6:0]] <= ex_tg[`RES_STG];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ex_v <= 5'h00;
      ex_br <= 5'h00;
      ex_pt <= 5'h00;
      ex_call <= 5'h00;
    end else begin
      ex_v <= {ex_v[3:0] & ~kill[3:0], fire && !trap};
      ex_br <= {ex_br[3:0], has_br && bw[`F_COND] && !bw[28]};
      ex_pt <= {ex_pt[3:0], pred};
      ex_call <= {ex_call[3:0], bw[`F_KIND] == BR_CALL};
    end
  end

  always_ff @(posedge MCLK_I) begin
    for (int s = `EX_STAGES - 1; s > 0; s--) begin
      ex_line[s] <= ex_line[s-1];
      ex_cnt[s] <= ex_cnt[s-1];
      ex_pc[s] <= ex_pc[s-1];
      ex_tg[s] <= ex_tg[s-1];
      ex_np[s] <= ex_np[s-1];
    end
    if (RESET_I) begin
      ex_line[0] <= 128'h0;
      ex_cnt[0] <= 3'd0;
      ex_pc[0] <= 16'h0000;
    end else begin
      for (int k = 0; k < `LINE_W; k++) begin
        ex_line[0][32*k +: 32] <= (k < int'(len)) ? q[k] : 32'h0000_0000;
      end
      ex_cnt[0] <= len;
      ex_pc[0] <= head_pc;
    end
    ex_tg[0] <= bw[`F_TGT];
    ex_np[0] <= next_pc;
  end

  assign ISSUE_LINE_O = ex_line[0];
  assign ISSUE_CNT_O = ex_cnt[0];
  assign ISSUE_PC_O = ex_pc[0];
  assign EXEC_VALID_O = ex_v;
  assign RETIRE_O = ex_v[`EX_STAGES-1];

  // ----------------------------------------
  // Fetch
  // ----------------------------------------
  assign FETCH_ADDR_O = fetch_pc;
  assign FETCH_REQ_O = !rd && out_n < 2'(`FE_STAGES)
    && 7'(wcnt) + 7'(out_n) * 7'd4 + 7'd4 <= 7'(QWORDS);
  assign push_acc = FETCH_VALID_I && drop == 2'd0 && !rd;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      fetch_pc <= 16'h0000;
      head_pc <= 16'h0000;
      skip <= 2'd0;
      out_n <= 2'd0;
      drop <= 2'd0;
    end else begin
      out_n <= out_n + 2'(FETCH_REQ_O) - 2'(FETCH_VALID_I);
      if (rd) begin
        fetch_pc <= {rd_pc[15:2], 2'b00};
        skip <= rd_pc[1:0];
        head_pc <= rd_pc;
        drop <= out_n - 2'(FETCH_VALID_I);
      end else begin
        if (FETCH_REQ_O) fetch_pc <= fetch_pc + 16'd4;
        if (FETCH_VALID_I && drop != 2'd0) drop <= drop - 2'd1;
        if (push_acc) skip <= 2'd0;
        if (fire) head_pc <= next_pc;
      end
    end
  end

  logic [5:0] npop, base, npush;
  assign npop = fire ? 6'(len) : 6'd0;
  assign base = wcnt - npop;
  assign npush = push_acc ? 6'd4 - 6'(skip) : 6'd0;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I || rd) begin
      wcnt <= 6'd0;
    end else begin
      wcnt <= base + npush;
    end
    for (int i = 0; i < QWORDS; i++) begin
      if (i + int'(npop) < int'(wcnt)) begin
        q[i] <= q[i + int'(npop)];
      end else if (i >= int'(base) && i < int'(base) + int'(npush)) begin
        q[i] <= FETCH_DATA_I[32*(i - int'(base) + int'(skip)) +: 32];
      end
    end
  end

  // ----------------------------------------
  // Events and statistics
  // ----------------------------------------
  always_comb begin
    ev = 4'h0;
    ev[`E_IRQ] = take;
    ev[`E_EXC] = ABORT_O;
    ev[`E_MISP] = mp;
    ev[`E_STALL] = STALL_O;
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      stalls <= 16'h0000;
    end else if (STALL_O && stalls != 16'hFFFF) begin
      stalls <= stalls + 16'd1;
    end
  end
endmodule

// *** rtl/seq_params.svh ***
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_LATCH 8'h00
`define A_MASK 8'h04
`define A_CTRL 8'h08
`define A_INSVC 8'h0C
`define A_STAT 8'h10
`define A_SMASK 8'h14
`define A_STALLS 8'h18
`define A_EXCVEC 8'h1C
`define A_VEC0 8'h20
`define A_VECN 8'h3C
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define C_GIE 0
`define C_NEST 1
`define C_EDGE 7:4
// ----------------------------------------
// Status events
// ----------------------------------------
`define E_IRQ 0
`define E_EXC 1
`define E_MISP 2
`define E_STALL 3
// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define F_LAST 31
`define F_CLS 30:29
`define F_SRCF 28
`define F_DST 27:23
`define F_SA 22:18
`define F_SB 17:13
`define F_KIND 28:27
`define F_COND 26
`define F_TRAP 28
`define F_TGT 15:0
// ----------------------------------------
// Pipeline shape and timing
// ----------------------------------------
`define FE_STAGES 3
`define EX_STAGES 5
`define RES_STG 2
`define LAT_CMP 2
`define LAT_INTEGER_ADDRESS_UNIT 1
`define NSRC 8
`define NEXT 4
`define LINE_W 4
`endif

// *** rtl/seq_pkg.sv ***
package seq_pkg;
  typedef enum logic [1:0] {CL_CMP, CL_INTEGER_ADDRESS_UNIT, CL_BR, CL_CTL} iclass_t;
  typedef enum logic [1:0] {BR_JUMP, BR_CALL, BR_RTS, BR_RTI} brkind_t;
  typedef enum logic {S_RUN, S_DRAIN} seq_state_t;
endpackage

// *** sim/seq_checker_properties.sv ***
`timescale 1ns/1ps
module seq_checker (
  input wire logic MCLK_I, // core clock
  input wire logic RESET_I, // synchronous reset
  input wire logic FETCH_REQ_O, // fetch request
  input wire logic [15:0] FETCH_ADDR_O, // fetch address
  input wire logic [127:0] ISSUE_LINE_O, // issued line
  input wire logic [2:0] ISSUE_CNT_O, // words in line
  input wire logic [15:0] ISSUE_PC_O, // line address
  input wire logic [4:0] EXEC_VALID_O, // stage valids
  input wire logic RETIRE_O, // line completing
  input wire logic STALL_O, // interlock stall
  input wire logic ABORT_O, // pipe aborted
  input wire seq_pkg::seq_state_t STATE_O // sequencer state
);
  import seq_pkg::*;
  logic plain;
  logic [7:0] last_idx;
  // A line with no branch or control word cannot redirect the flow.
  assign plain = !(ISSUE_LINE_O[30] | ISSUE_LINE_O[62] | ISSUE_LINE_O[94] | ISSUE_LINE_O[126]);
  assign last_idx = {ISSUE_CNT_O - 3'h1, 5'h1f};
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_plain_issue;
    EXEC_VALID_O[0] && plain;
  endsequence
  sequence s_cmp_issue;
    EXEC_VALID_O[0] && ISSUE_LINE_O[30:29] == 2'h0;
  endsequence
  sequence s_drain_start;
    $rose(STATE_O == S_DRAIN);
  endsequence
  a_retire_after_issue:
    assert property (RETIRE_O |-> $past(EXEC_VALID_O[0], 4)) else $error("retire without issue");
  a_dep_gap:
    assert property (s_cmp_issue ##1 (EXEC_VALID_O[0] && !ISSUE_LINE_O[30] && !ISSUE_LINE_O[28])
      |-> ISSUE_LINE_O[22:18] != $past(ISSUE_LINE_O[27:23])
      && ISSUE_LINE_O[17:13] != $past(ISSUE_LINE_O[27:23])) else $error("dependent issued early");
  a_stall_blocks:
    assert property (STALL_O |=> !EXEC_VALID_O[0]) else $error("issue during stall");
  a_line_shape:
    assert property (EXEC_VALID_O[0] |-> ISSUE_CNT_O inside {[1:4]} && ISSUE_LINE_O[last_idx])
      else $error("bad line shape");
  a_fetch_aligned:
    assert property (FETCH_REQ_O |-> FETCH_ADDR_O[1:0] == 2'h0) else $error("unaligned fetch");
  a_order_pc:
    assert property (s_plain_issue ##1 EXEC_VALID_O[0]
      |-> ISSUE_PC_O == $past(ISSUE_PC_O) + {13'h0, $past(ISSUE_CNT_O)})
      else $error("out of order");
  a_abort_kills:
    assert property (ABORT_O |=> EXEC_VALID_O[4:1] == 4'h0) else $error("abort left lines");
  a_drain_quiet:
    assert property (STATE_O == S_DRAIN |-> !EXEC_VALID_O[0] && !ABORT_O)
      else $error("drain issue");
  a_drain_bounded:
    assert property (s_drain_start |-> ##[1:12] STATE_O == S_RUN) else $error("drain too long");
endmodule
bind program_sequencer_interrupt_ctrl seq_checker chk_u (
  .MCLK_I(MCLK_I),
  .RESET_I(RESET_I),
  .FETCH_REQ_O(FETCH_REQ_O),
  .FETCH_ADDR_O(FETCH_ADDR_O),
  .ISSUE_LINE_O(ISSUE_LINE_O),
  .ISSUE_CNT_O(ISSUE_CNT_O),
  .ISSUE_PC_O(ISSUE_PC_O),
  .EXEC_VALID_O(EXEC_VALID_O),
  .RETIRE_O(RETIRE_O),
  .STALL_O(STALL_O),
  .ABORT_O(ABORT_O),
  .STATE_O(STATE_O)
);

// *** sim/imem_model.sv ***
`timescale 1ns/1ps
module imem_model (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // reset
  input wire logic req_i, // fetch request
  input wire logic [15:0] addr_i, // block word address
  input wire logic [1:0] lat_i, // extra wait cycles
  output logic valid_o, // block returned
  output logic [127:0] data_o // block words
);
  logic [31:0] mem [0:255];
  logic [15:0] pend [$];
  logic [1:0] wait_c = 2'h0;
  logic [7:0] a;
  initial valid_o = 1'b0;
  initial data_o = '0;
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    // Idle data toggles so a stale block is never mistaken for a fresh one.
    data_o <= ~data_o;
    if (rst_i) begin
      pend.delete();
    end else begin
      if (req_i) pend.push_back(addr_i);
      if (pend.size() > 0 && wait_c != 2'h0) begin
        wait_c <= wait_c - 2'h1;
      end else if (pend.size() > 0) begin
        a = 8'(pend.pop_front());
        valid_o <= 1'b1;
        data_o <= {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]};
        wait_c <= lat_i;
      end
    end
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  import seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_seen = 1'b0;
  logic [3:0] int_src = 4'h0;
  logic cond = 1'b1;
  logic [3:0] ext_n = 4'hf;
  logic [7:0] seed = 8'h3d;
  logic [31:0] rdata;
  logic freq, fvalid, retire, stall, abort_p, irq;
  logic [15:0] faddr, ipc;
  logic [127:0] fdata, iline;
  logic [2:0] icnt;
  logic [4:0] evalid;
  seq_state_t state;
  int cyc = 0;
  int n = 0;
  int ts [0:15];
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] rd_q [$];
  logic [31:0] exp_q [$] = '{32'h0001_0000, 32'h0001_0001, 32'h0001_0002, 32'h0001_0003,
    32'h0003_0004, 32'h0004_0007, 32'h0001_000b, 32'h0001_0020, 32'h0001_0040, 32'h0001_0050};
  always #12.5 clk = ~clk;
  program_sequencer_interrupt_ctrl #(.BTC_N(128), .QWORDS(20), .INT_EDGE(4'h3)) dut (
    .MCLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_en), .RD_I(rd_en),
    .RDATA_O(rdata), .FETCH_REQ_O(freq), .FETCH_ADDR_O(faddr), .FETCH_VALID_I(fvalid),
    .FETCH_DATA_I(fdata), .COND_I(cond), .EXT_IRQ_N_I(ext_n), .INT_SRC_I(int_src),
    .ISSUE_LINE_O(iline), .ISSUE_CNT_O(icnt), .ISSUE_PC_O(ipc), .EXEC_VALID_O(evalid),
    .RETIRE_O(retire), .STALL_O(stall), .ABORT_O(abort_p), .STATE_O(state), .IRQ_O(irq));
  imem_model mem_u (.clk_i(clk), .rst_i(rst), .req_i(freq), .addr_i(faddr), .lat_i(seed[1:0]),
    .valid_o(fvalid), .data_o(fdata));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] ins(input logic [3:0] h, input logic [4:0] d, s1, s2);
    return {h, d, s1, s2, 13'h0};
  endfunction
  function automatic logic [31:0] br(input logic [2:0] kc, input logic [15:0] t);
    return {3'h6, kc, 10'h0, t};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic drain_wait;
    for (int k = 0; k < 2000 && exp_q.size() > 0; k++) @(posedge clk);
    chk("lines left", exp_q.size(), 0);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor: issued lines and read data
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seed <= lfsr(seed);
    rd_seen <= rd_en;
    if (rd_seen) chk("read data", rdata, rd_q.pop_front());
    if (evalid[0] && ipc !== 16'h0021 && n < 16) begin
      ts[n] = cyc;
      n = n + 1;
      chk("issue", {13'h0, icnt, ipc}, exp_q.size() > 0 ? exp_q.pop_front() : '1);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    for (int i = 0; i < 256; i++) mem_u.mem[i] = 32'h0000_0000;
    mem_u.mem[0] = ins(4'h8, 5'h01, 5'h03, 5'h04);
    mem_u.mem[1] = ins(4'h8, 5'h05, 5'h01, 5'h06);
    mem_u.mem[2] = ins(4'hb, 5'h02, 5'h07, 5'h08);
    mem_u.mem[3] = ins(4'hb, 5'h09, 5'h02, 5'h03);
    for (int i = 4; i < 11; i++)
      mem_u.mem[i] = ins((i == 6 || i == 10) ? 4'h8 : 4'h0, 5'h0a, 5'h00, 5'h00);
    mem_u.mem[11] = br(3'h0, 16'h0020);
    mem_u.mem[32] = ins(4'h8, 5'h0b, 5'h00, 5'h00);
    mem_u.mem[33] = 32'hf000_0000;
    mem_u.mem[64] = br(3'h1, 16'h0050);
    mem_u.mem[80] = ins(4'h8, 5'h0d, 5'h00, 5'h00);
    mem_u.mem[96] = br(3'h6, 16'h0000);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus_wr(8'h1c, 32'h0000_0040);
    bus_wr(8'h30, 32'h0000_0060);
    bus_wr(8'h14, 32'h0000_0002);
    bus_wr(8'h04, 32'h0000_0010);
    bus_rd(8'h04, 32'h0000_0010);
    bus_rd(8'h80, 32'h0000_0000);
    drain_wait();
    chk("compute gap", ts[1] - ts[0], 2);
    chk("plain gap", ts[2] - ts[1], 1);
    chk("integer gap", ts[3] - ts[2], 1);
    repeat (10) @(posedge clk);
    bus_rd(8'h10, 32'h0000_000e);
    chk("irq high", {31'h0, irq}, 1);
    exp_q.push_back(32'h0001_0060);
    bus_wr(8'h08, 32'h0000_0001);
    int_src <= 4'h3;
    drain_wait();
    int_src <= 4'h0;
    repeat (10) @(posedge clk);
    bus_rd(8'h0c, 32'h0000_0000);
    bus_rd(8'h00, 32'h0000_0020);
    bus_rd(8'h10, 32'h0000_000f);
    bus_rd(8'h18, 32'h0000_0001);
    // Pin 0 in level mode re-latches while low; pin 1 in edge mode latches once.
    ext_n <= 4'he;
    repeat (8) @(posedge clk);
    bus_rd(8'h00, 32'h0000_0021);
    ext_n <= 4'hf;
    repeat (8) @(posedge clk);
    bus_wr(8'h00, 32'h0000_0001);
    bus_rd(8'h00, 32'h0000_0020);
    bus_wr(8'h08, 32'h0000_0021);
    ext_n <= 4'hd;
    repeat (8) @(posedge clk);
    bus_rd(8'h00, 32'h0000_0022);
    bus_wr(8'h00, 32'h0000_0002);
    bus_rd(8'h00, 32'h0000_0020);
    ext_n <= 4'hf;
    bus_wr(8'h10, 32'h0000_000f);
    bus_rd(8'h10, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irq low", {31'h0, irq}, 0);
    results();
  end
endmodule
